// ### aih_top.sv
// assigned input handler: input sampling, jog, limits, start, home, reset, kill and position capture
//
// Design decisions made here: the AHB-Lite interface to the registers and the register addresses.
`include "aih_map.svh"

// Operation
// - jog input active ramps jog velocity up at accel rate, added to other motion.
// - jog is level driven and moves only while ready and enabled.
// - jog input inactive ramps jog velocity to zero at decel rate.
// - enabled limits must both be closed to enable motor or start user programs.
// - limit opening aborts program, then error program 27 runs once motion rests.
// - deactivating edges of limit, start, home, reset and capture inputs do nothing.
// - pause flag follows the pause input level.
// - start rising edge launches default or selected program if ready, enabled, idle.
// - with start input disabled, start pin launches nothing.
// - define home edge requests position zero unless a program runs.
// - while hardware reset is active, the stop-diagnose-ready-enable-auto cycle repeats.
// - stop flag follows kill input level, halting program motion and execution.
// - kill does not cancel jog; jog slows to rest then resumes.
// - up to six select lines, input sixteen the top bit, decode binary.
// - programs 32 to 63 need the expansion card present.
// - inputs eleven and twelve capture both encoders and set occurred flags.
// - input eleven can latch one chosen encoder into the latched position.
// - software capture within 50 us, hardware latch within 1.5 us.
// - each capture event captures only while its enable is set.
// - software can force capture event two like its input.
// - inputs sampled into flags once per 1 ms tick.
module aih_top #(
  parameter int TICK_CYCLES = `AIH_TICK_CYCLES,
  parameter int VW = 16
) (
  // ahb-lite slave
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // digital input pins, bit n is input n+1
  input wire logic [15:0] din,
  // system state from the controller
  input wire logic sys_ready,
  input wire logic sys_enabled,
  input wire logic main_running,
  input wire logic any_running,
  input wire logic motion_at_rest,
  input wire logic expansion_present,
  input wire logic diag_done,
  input wire logic fault_present,
  input wire logic enable_input,
  // encoder counters
  input wire logic [31:0] enc_a_pos,
  input wire logic [31:0] enc_b_pos,
  // actions toward sequencer and motion generator
  output logic signed [VW-1:0] jog_vel_cmd,
  output logic limits_ok,
  output logic pause_flag,
  output logic stop_flag,
  output logic abort_program,
  output logic program_start,
  output logic [5:0] program_num,
  output logic program_system,
  output logic define_home_request,
  output logic [2:0] hreset_phase
);
  aih_pkg::aih_state_s s_q, s_d;
  logic signed [VW-1:0] jog_target;
  logic signed [VW-1:0] jog_vel;
  logic ahb_go;
  logic [2:0] nsel;
  logic [5:0] sel_num;
  logic [5:0] start_num;
  logic lim_fault, lim_rise, start_rise, dh_rise, hr_on, kill_on;
  logic rise1, rise2, cap1, cap2, force2;
  logic jog_fwd, jog_rev, jog_allow;

  // pick one input flag by its assigned index
  function automatic logic pick(input logic [15:0] f, input logic [3:0] idx);
    pick = f[idx];
  endfunction

  // ----------------------------------------
  // jog ramp
  // ----------------------------------------
  aih_jog_ramp #(
    .W(VW)
  ) u_ramp (
    .clk(hclk),
    .rst_n(hresetn),
    .tick(s_q.tick),
    .target(jog_target),
    .accel_rate(s_q.jacc),
    .decel_rate(s_q.jdec),
    .vel(jog_vel)
  );

  // ----------------------------------------
  // decoded conditions
  // ----------------------------------------
  // edges compare this tick's flags with the previous tick's
  always_comb begin
    // a transfer is taken only when selected, ready and marked valid by the master
    ahb_go = hsel && hready && htrans[1];
    lim_fault = s_q.flags[`AIH_PIN_LIM_FWD] || s_q.flags[`AIH_PIN_LIM_REV];
    lim_rise = s_q.tick && s_q.ctrl[`AIH_CTRL_LIMIT_EN]
      && ((s_q.flags[`AIH_PIN_LIM_FWD] && !s_q.flags_prev[`AIH_PIN_LIM_FWD])
      || (s_q.flags[`AIH_PIN_LIM_REV] && !s_q.flags_prev[`AIH_PIN_LIM_REV]));
    start_rise = s_q.tick && s_q.flags[`AIH_PIN_START] && !s_q.flags_prev[`AIH_PIN_START];
    dh_rise = s_q.tick && s_q.asn[`AIH_ASN_DH_EN] && pick(s_q.flags, s_q.asn[3:0])
      && !pick(s_q.flags_prev, s_q.asn[3:0]);
    hr_on = s_q.asn[`AIH_ASN_HR_EN] && pick(s_q.flags, s_q.asn[7:4]);
    kill_on = s_q.asn[`AIH_ASN_KILL_EN] && pick(s_q.flags, s_q.asn[11:8]);
    // capture pins are watched every clock so the capture is not held to the tick
    rise1 = din[`AIH_PIN_CAPTURE_ONE_ENABLE] && !s_q.pin_prev[0];
    rise2 = din[`AIH_PIN_CAPTURE_TWO_ENABLE] && !s_q.pin_prev[1];
    // the force bit only counts in the data phase of a command write
    force2 = s_q.wr_pend && s_q.wr_addr == `AIH_OFS_CMD && hwdata[`AIH_CMD_FORCE2];
    cap1 = rise1 && s_q.ctrl[`AIH_CTRL_CAP1_EN];
    cap2 = s_q.ctrl[`AIH_CTRL_CAP2_EN] && (rise2 || force2);

    // select lines: top n of inputs sixteen..eleven, count clamped to 2..6
    nsel = s_q.ctrl[`AIH_CTRL_NSEL_LSB +: 3];
    if (nsel < `AIH_NSEL_MIN) begin
      nsel = `AIH_NSEL_MIN;
    end else if (nsel > `AIH_NSEL_MAX) begin
      nsel = `AIH_NSEL_MAX;
    end
    sel_num = s_q.flags[15:10] >> (`AIH_NSEL_MAX - nsel);
    start_num = s_q.ctrl[`AIH_CTRL_START_SEL] ? sel_num : s_q.def_prog;

    // jog target: kill forces a rest first, then jog resumes
    jog_fwd = s_q.flags[`AIH_PIN_JOG_FWD];
    jog_rev = s_q.flags[`AIH_PIN_JOG_REV];
    jog_allow = s_q.ctrl[`AIH_CTRL_JOG_EN] && sys_ready && sys_enabled && !s_q.kill_hold;
    if (jog_allow && jog_fwd && !jog_rev) begin
      jog_target = $signed(s_q.jog_velocity);
    end else if (jog_allow && jog_rev && !jog_fwd) begin
      jog_target = VW'(-$signed(s_q.jog_velocity));
    end else begin
      jog_target = '0;
    end
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    s_d = s_q;
    // one-cycle pulses fall back low unless set again below
    s_d.prog_start = 1'b0;
    s_d.abort = 1'b0;
    s_d.def_home = 1'b0;
    s_d.wr_pend = 1'b0;

    // control tick divider and input sampling
    s_d.tick = 1'b0;
    if (s_q.cnt >= 32'(TICK_CYCLES - 1)) begin
      s_d.cnt = '0;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + 32'd1;
    end
    if (s_d.tick) begin
      s_d.flags_prev = s_q.flags;
      s_d.flags = din;
    end
    s_d.pin_prev = {din[`AIH_PIN_CAPTURE_TWO_ENABLE], din[`AIH_PIN_CAPTURE_ONE_ENABLE]};

    // level-following flags
    // both move only on ticks, as program logic reads flags and not pins
    if (s_q.tick) begin
      s_d.stop = kill_on;
    end
    // the hold is set once at the kill edge, so jog resumes after the rest
    if (s_q.tick && kill_on && !s_q.stop) begin
      s_d.kill_hold = 1'b1;
    end else if (s_q.kill_hold && jog_vel == '0) begin
      s_d.kill_hold = 1'b0;
    end

    // travel limit fault: abort now, error program once motion rests
    // waiting for rest keeps the error program off a still-moving axis
    if (lim_rise) begin
      s_d.abort = any_running;
      s_d.err_pend = 1'b1;
    end

    // hardware reset cycle
    // diagnostics take an unknown number of clocks, so that phase waits on the controller
    // the cycle restarts from the stop phase while the reset input stays on
    case (s_q.hr)
      aih_pkg::AIH_HR_IDLE: begin
        if (hr_on) begin
          s_d.hr = aih_pkg::AIH_HR_STOP;
        end
      end
      aih_pkg::AIH_HR_STOP: s_d.hr = aih_pkg::AIH_HR_DIAG;
      aih_pkg::AIH_HR_DIAG: begin
        if (diag_done) begin
          s_d.hr = aih_pkg::AIH_HR_READY;
        end
      end
      aih_pkg::AIH_HR_READY: s_d.hr = aih_pkg::AIH_HR_ENABLE;
      aih_pkg::AIH_HR_ENABLE: s_d.hr = aih_pkg::AIH_HR_AUTO;
      aih_pkg::AIH_HR_AUTO: begin
        s_d.prog_start = 1'b1;
        s_d.prog_num = `AIH_PROG_AUTO;
        s_d.prog_sys = 1'b1;
        s_d.hr = hr_on ? aih_pkg::AIH_HR_STOP : aih_pkg::AIH_HR_IDLE;
      end
      default: s_d.hr = aih_pkg::AIH_HR_IDLE;
    endcase

    // program launch, lower priority than the reset cycle
    // a start edge seen during the reset cycle is dropped, not queued
    if (s_q.hr == aih_pkg::AIH_HR_IDLE && !hr_on) begin
      if (s_q.err_pend && motion_at_rest && !lim_rise) begin
        s_d.err_pend = 1'b0;
        s_d.prog_start = 1'b1;
        s_d.prog_num = `AIH_PROG_ERROR;
        s_d.prog_sys = 1'b1;
      end else if (start_rise && s_q.ctrl[`AIH_CTRL_START_EN]) begin
        if (sys_ready && sys_enabled && !main_running && limits_ok
          && (start_num <= `AIH_PROG_BASE_MAX || expansion_present)) begin
          s_d.prog_start = 1'b1;
          s_d.prog_num = start_num;
          s_d.prog_sys = 1'b0;
          s_d.refused = 1'b0;
        end else begin
          s_d.refused = 1'b1;
        end
      end
    end

    // only a request: the position counter does the zeroing itself
    if (dh_rise && !any_running) begin
      s_d.def_home = 1'b1;
    end

    // ahb address phase: latch writes, prepare read data
    // read data is registered so hrdata stands through the data phase
    if (ahb_go) begin
      s_d.wr_pend = hwrite;
      s_d.wr_addr = haddr[7:0];
      s_d.rdata = '0;
      case (haddr[7:0])
        `AIH_OFS_CTRL: s_d.rdata = {16'h0000, s_q.ctrl};
        `AIH_OFS_ASSIGN: s_d.rdata = {16'h0000, s_q.asn};
        `AIH_OFS_DEFPROG: s_d.rdata = {26'h0000000, s_q.def_prog};
        `AIH_OFS_JOG_VELOCITY: s_d.rdata = {16'h0000, s_q.jog_velocity};
        `AIH_OFS_JACC: s_d.rdata = {16'h0000, s_q.jacc};
        `AIH_OFS_JDEC: s_d.rdata = {16'h0000, s_q.jdec};
        `AIH_OFS_STATUS: begin
          // bits above the reset phase read zero
          s_d.rdata = {5'h00, s_q.hr, s_q.refused, s_q.err_pend, lim_fault,
            jog_vel != '0, s_q.stop, s_q.flags[`AIH_PIN_PAUSE],
            s_q.occ2, s_q.occ1, s_q.flags};
        end
        `AIH_OFS_C1A: s_d.rdata = s_q.c1a;
        `AIH_OFS_C1B: s_d.rdata = s_q.c1b;
        `AIH_OFS_C2A: s_d.rdata = s_q.c2a;
        `AIH_OFS_C2B: s_d.rdata = s_q.c2b;
        `AIH_OFS_LATCHED_POSITION: s_d.rdata = s_q.latched_position;
        default: s_d.rdata = '0;
      endcase
    end

    // ahb data phase writes
    // the jog velocity keeps its sign bit clear; direction comes from the pins
    if (s_q.wr_pend) begin
      case (s_q.wr_addr)
        `AIH_OFS_CTRL: s_d.ctrl = hwdata[15:0];
        `AIH_OFS_ASSIGN: s_d.asn = hwdata[15:0];
        `AIH_OFS_DEFPROG: s_d.def_prog = hwdata[5:0];
        `AIH_OFS_JOG_VELOCITY: s_d.jog_velocity = {1'b0, hwdata[14:0]};
        `AIH_OFS_JACC: s_d.jacc = hwdata[15:0];
        `AIH_OFS_JDEC: s_d.jdec = hwdata[15:0];
        `AIH_OFS_CMD: begin
          if (hwdata[`AIH_CMD_CLR1]) begin
            s_d.occ1 = 1'b0;
          end
          if (hwdata[`AIH_CMD_CLR2]) begin
            s_d.occ2 = 1'b0;
          end
        end
        default: s_d.ctrl = s_q.ctrl;
      endcase
    end

    // placed after the writes so that a same-cycle clear loses
    // captures land in the clock after the edge; a capture beats a same-cycle clear
    if (cap1) begin
      s_d.c1a = enc_a_pos;
      s_d.c1b = enc_b_pos;
      s_d.occ1 = 1'b1;
    end
    if (cap2) begin
      s_d.c2a = enc_a_pos;
      s_d.c2b = enc_b_pos;
      s_d.occ2 = 1'b1;
    end
    if (rise1 && s_q.ctrl[`AIH_CTRL_LATCH_EN]) begin
      s_d.latched_position = s_q.ctrl[`AIH_CTRL_LATCH_SEL] ? enc_b_pos : enc_a_pos;
    end
  end

  // state register
  // reset values come from the map header so software reads them at once
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '0;
      s_q.ctrl <= `AIH_CTRL_RST;
      s_q.asn <= `AIH_ASSIGN_RST;
      s_q.hr <= aih_pkg::AIH_HR_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // zero wait states and an always-OKAY response: no error path is needed
  assign hrdata = s_q.rdata;
  assign hreadyout = 1'b1; // never waits: all registers answer in one data phase
  assign hresp = 1'b0;
  assign jog_vel_cmd = jog_vel;
  assign limits_ok = !s_q.ctrl[`AIH_CTRL_LIMIT_EN] || !lim_fault;
  assign pause_flag = s_q.ctrl[`AIH_CTRL_PAUSE_EN] && s_q.flags[`AIH_PIN_PAUSE];
  assign stop_flag = s_q.stop;
  assign abort_program = s_q.abort;
  assign program_start = s_q.prog_start;
  assign program_num = s_q.prog_num;
  assign program_system = s_q.prog_sys;
  assign define_home_request = s_q.def_home;
  assign hreset_phase = s_q.hr;
endmodule // aih_top

// ### aih_map.svh
// register offsets, field positions, reset values and timing counts of the assigned input handler
`ifndef AIH_MAP_SVH
`define AIH_MAP_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define AIH_OFS_CTRL 8'h00
`define AIH_OFS_ASSIGN 8'h04
`define AIH_OFS_DEFPROG 8'h08
`define AIH_OFS_JOG_VELOCITY 8'h0C
`define AIH_OFS_JACC 8'h10
`define AIH_OFS_JDEC 8'h14
`define AIH_OFS_STATUS 8'h18
`define AIH_OFS_CMD 8'h1C
`define AIH_OFS_C1A 8'h20
`define AIH_OFS_C1B 8'h24
`define AIH_OFS_C2A 8'h28
`define AIH_OFS_C2B 8'h2C
`define AIH_OFS_LATCHED_POSITION 8'h30
// ----------------------------------------
// control fields
// ----------------------------------------
`define AIH_CTRL_LIMIT_EN 0
`define AIH_CTRL_START_EN 1
`define AIH_CTRL_START_SEL 2
`define AIH_CTRL_CAP1_EN 3
`define AIH_CTRL_CAP2_EN 4
`define AIH_CTRL_LATCH_SEL 5
`define AIH_CTRL_LATCH_EN 6
`define AIH_CTRL_PAUSE_EN 7
`define AIH_CTRL_JOG_EN 8
`define AIH_CTRL_NSEL_LSB 9
`define AIH_CTRL_RST 16'h0C00
`define AIH_ASSIGN_RST 16'h0000
`define AIH_ASN_DH_EN 12
`define AIH_ASN_HR_EN 13
`define AIH_ASN_KILL_EN 14
// command bits
`define AIH_CMD_FORCE2 0
`define AIH_CMD_CLR1 1
`define AIH_CMD_CLR2 2
// ----------------------------------------
// input pin positions (bit = input number - 1)
// ----------------------------------------
`define AIH_PIN_LIM_FWD 0
`define AIH_PIN_LIM_REV 1
`define AIH_PIN_START 3
`define AIH_PIN_JOG_FWD 6
`define AIH_PIN_JOG_REV 7
`define AIH_PIN_PAUSE 8
`define AIH_PIN_CAPTURE_ONE_ENABLE 10
`define AIH_PIN_CAPTURE_TWO_ENABLE 11
`define AIH_PIN_SEL_LSB 10
// ----------------------------------------
// programs and timing
// ----------------------------------------
`define AIH_PROG_ERROR 6'd27
`define AIH_PROG_AUTO 6'd0
`define AIH_PROG_BASE_MAX 6'd31
`define AIH_NSEL_MIN 3'd2
`define AIH_NSEL_MAX 3'd6
`define AIH_CLK_NS 10
`define AIH_TICK_NS 1000000
`define AIH_TICK_CYCLES (`AIH_TICK_NS / `AIH_CLK_NS)
`endif

// ### aih_pkg.sv
// types shared by the assigned input handler modules
package aih_pkg;
  // hardware reset cycle phases
  typedef enum logic [2:0] {
    AIH_HR_IDLE = 3'b000,
    AIH_HR_STOP = 3'b001,
    AIH_HR_DIAG = 3'b010,
    AIH_HR_READY = 3'b011,
    AIH_HR_ENABLE = 3'b100,
    AIH_HR_AUTO = 3'b101
  } aih_hr_e;

  // complete state of the top module
  typedef struct packed {
    logic [31:0] cnt;
    logic tick;
    logic [15:0] flags;
    logic [15:0] flags_prev;
    logic [1:0] pin_prev;
    logic [15:0] ctrl;
    logic [15:0] asn;
    logic [5:0] def_prog;
    logic [15:0] jog_velocity;
    logic [15:0] jacc;
    logic [15:0] jdec;
    logic occ1;
    logic occ2;
    logic [31:0] c1a;
    logic [31:0] c1b;
    logic [31:0] c2a;
    logic [31:0] c2b;
    logic [31:0] latched_position;
    logic err_pend;
    logic refused;
    logic stop;
    logic kill_hold;
    aih_hr_e hr;
    logic prog_start;
    logic [5:0] prog_num;
    logic prog_sys;
    logic abort;
    logic def_home;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] rdata;
  } aih_state_s;
endpackage

// ### aih_jog_ramp.sv
// jog velocity ramp generator, one step per control tick
module aih_jog_ramp #(
  parameter int W = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic tick,
  input wire logic signed [W-1:0] target,
  input wire logic [W-1:0] accel_rate,
  input wire logic [W-1:0] decel_rate,
  // result
  output logic signed [W-1:0] vel
);
  typedef struct packed {
    logic signed [W-1:0] vel;
  } aih_ramp_s;

  aih_ramp_s s_q, s_d;
  logic signed [W:0] diff;
  logic [W:0] mag;
  logic up;
  logic [W-1:0] rate;

  // ----------------------------------------
  // ramp step
  // ----------------------------------------
  // magnitude growing uses the accel rate, shrinking the decel rate
  always_comb begin
    s_d = s_q;
    diff = {target[W-1], target} - {s_q.vel[W-1], s_q.vel};
    mag = diff[W] ? (W+1)'(-diff) : diff;
    up = (!s_q.vel[W-1] && !diff[W] && diff != '0) || ((s_q.vel[W-1] || s_q.vel == '0) && diff[W]);
    rate = up ? accel_rate : decel_rate;
    if (tick) begin
      if (mag <= {1'b0, rate}) begin
        s_d.vel = target;
      end else if (diff[W]) begin
        s_d.vel = W'(s_q.vel - $signed({1'b0, rate}));
      end else begin
        s_d.vel = W'(s_q.vel + $signed({1'b0, rate}));
      end
    end
  end

  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign vel = s_q.vel;
endmodule // aih_jog_ramp

// ### aih_top_props.sv
// concurrent checks on the ports of the assigned input handler
module aih_top_props #(
  parameter int TICK_CYCLES = 8,
  parameter int VW = 16
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // controller state
  input wire logic any_running,
  input wire logic main_running,
  input wire logic sys_ready,
  input wire logic sys_enabled,
  input wire logic expansion_present,
  // actions
  input wire logic limits_ok,
  input wire logic pause_flag,
  input wire logic abort_program,
  input wire logic program_start,
  input wire logic [5:0] program_num,
  input wire logic program_system,
  input wire logic define_home_request,
  input wire logic [2:0] hreset_phase
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // ----------------------------------------
  // program launch
  // ----------------------------------------
  AST_START_PULSE: assert property (program_start |=> !program_start)
    else $error("program start pulse longer than one cycle");
  AST_START_COND: assert property (program_start && !program_system |-> $past(sys_ready && sys_enabled && !main_running))
    else $error("user program started while not ready, disabled or busy");
  AST_START_LIMITS: assert property (program_start && !program_system |-> limits_ok)
    else $error("user program started with a travel limit open");
  AST_START_BANK: assert property (program_start && !program_system && program_num > 6'd31 |-> $past(expansion_present))
    else $error("upper program bank used without expansion card");
  AST_SYS_PROG: assert property (program_start && program_system |-> program_num inside {6'd27, 6'd0})
    else $error("system program number is neither error nor auto");
  AST_ABORT_LIMIT: assert property (abort_program |-> !limits_ok)
    else $error("abort raised with both limits closed");
  // ----------------------------------------
  // flags and reset cycle
  // ----------------------------------------
  AST_HOME_IDLE: assert property (define_home_request |-> !$past(any_running))
    else $error("define home honoured while a program ran");
  // flags move only on ticks, so a new level holds for a whole tick
  AST_PAUSE_HOLD: assert property ($rose(pause_flag) |=> $stable(pause_flag) [*6])
    else $error("pause flag changed between control ticks");
  AST_HR_ORDER: assert property ($changed(hreset_phase) && hreset_phase > 3'd1 |-> hreset_phase == $past(hreset_phase) + 3'd1)
    else $error("hardware reset phase skipped a step");

  COV_USER_START: cover property (program_start && !program_system);
  COV_ERR_PROG: cover property (program_start && program_system && program_num == 6'd27);
  COV_ABORT: cover property (abort_program);
  COV_HR_AUTO: cover property (hreset_phase == 3'd5);
endmodule // aih_top_props

bind aih_top aih_top_props #(.TICK_CYCLES(TICK_CYCLES), .VW(VW)) props_u (
  .hclk, .hresetn, .any_running, .main_running, .sys_ready, .sys_enabled, .expansion_present, .limits_ok,
  .pause_flag, .abort_program, .program_start, .program_num, .program_system, .define_home_request, .hreset_phase
);

// ### aih_sw_model.sv
// switch and sensor model that drives the handler's input pins
module aih_sw_model (
  // clock
  input wire logic clk,
  // wanted switch levels
  input wire logic [15:0] want,
  // pins toward the handler
  output logic [15:0] pins
);
  timeunit 1ns;
  timeprecision 1ps;
  // contacts move just after an edge; limits stay closed (low) unless a fault is wanted
  always_ff @(posedge clk) begin
    pins <= want;
  end
endmodule // aih_sw_model

// ### tb_top.sv
// self-checking bench for the assigned input handler
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready, hreadyout, hresp;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rv;
  logic [1:0] htrans = 2'b00;
  logic [2:0] hsize = 3'h2, hreset_phase;
  logic [15:0] sw_want = 16'h0, din;
  logic sys_ready = 1'b1, sys_enabled = 1'b1, main_running = 1'b0, any_running = 1'b0, motion_at_rest = 1'b0;
  logic expansion_present = 1'b0, diag_done = 1'b0, fault_present = 1'b0, enable_input = 1'b1;
  logic [31:0] enc_a_pos = 32'h1234_5678, enc_b_pos = 32'h0000_ABCD;
  logic signed [15:0] jog_vel_cmd;
  logic limits_ok, pause_flag, stop_flag, abort_program, program_start, program_system, define_home_request;
  logic [5:0] program_num, last_num = 6'h0;
  logic last_sys = 1'b0;
  int n_errors = 0, total_checks = 0, n_start = 0, n_abort = 0, n_home = 0;

  assign hready = hreadyout;
  always #5 hclk = ~hclk;

  aih_top #(.TICK_CYCLES(8), .VW(16)) dut_u (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready, .hwdata, .hrdata, .hreadyout, .hresp,
    .din, .sys_ready, .sys_enabled, .main_running, .any_running, .motion_at_rest, .expansion_present,
    .diag_done, .fault_present, .enable_input, .enc_a_pos, .enc_b_pos, .jog_vel_cmd, .limits_ok,
    .pause_flag, .stop_flag, .abort_program, .program_start, .program_num, .program_system,
    .define_home_request, .hreset_phase
  );
  aih_sw_model sw_u (.clk(hclk), .want(sw_want), .pins(din));

  // pulses last one cycle, so they are counted as they pass
  always @(posedge hclk) begin
    if (program_start === 1'b1) begin
      n_start++;
      last_num = program_num;
      last_sys = program_system;
    end
    if (abort_program === 1'b1) n_abort++;
    if (define_home_request === 1'b1) n_home++;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic finish_test();
    if (n_errors == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask

  // the slave never stretches a phase; a stuck bus still ends the run instead of hanging
  task automatic wait_ready();
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hready !== 1'b1 && k < 50);
    if (hready !== 1'b1) begin
      n_errors++;
      finish_test();
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= wr;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] x);
    bus(1'b0, a, 32'h0, x);
  endtask

  // select lines settle before the start edge; count covers both start edges
  task automatic start_try(input logic [31:0] c, input logic [5:0] sel, input int inc, input logic [5:0] num);
    int n0;
    n0 = n_start;
    wr(8'h00, c);
    sw_want[15:10] <= sel;
    cyc(24);
    sw_want[3] <= 1'b1;
    cyc(40);
    sw_want[3] <= 1'b0;
    cyc(40);
    chk("start count", 32'(n_start - n0), 32'(inc));
    chk("program number", {26'h0, last_num}, {26'h0, num});
  endtask

  task automatic pin(input int i, input logic v, input int n);
    sw_want[i] <= v;
    cyc(n);
  endtask

  initial begin
    cyc(50000);
    n_errors++;
    finish_test();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    cyc(3);
    hresetn <= 1'b1;
    cyc(1);
    rd(8'h00, rv);
    chk("ctrl reset", rv, 32'h0000_0C00);
    rd(8'h40, rv);
    chk("unmapped read", rv, 32'h0);
    wr(8'h00, 32'h0000_0C80);
    pin(8, 1'b1, 40);
    chk("pause on", {31'h0, pause_flag}, 32'h1);
    pin(8, 1'b0, 40);
    chk("pause off", {31'h0, pause_flag}, 32'h0);
    wr(8'h0C, 32'h4);
    wr(8'h10, 32'h2);
    wr(8'h14, 32'h1);
    wr(8'h00, 32'h0000_0D00);
    sys_enabled <= 1'b0;
    pin(6, 1'b1, 40);
    chk("jog disabled", 32'(jog_vel_cmd), 32'h0);
    sys_enabled <= 1'b1;
    cyc(40);
    chk("jog forward", 32'(jog_vel_cmd), 32'h4);
    pin(6, 1'b0, 16);
    chk("jog decel", 32'(jog_vel_cmd > 16'sh0), 32'h1);
    cyc(60);
    chk("jog rest", 32'(jog_vel_cmd), 32'h0);
    pin(7, 1'b1, 40);
    chk("jog reverse", 32'(jog_vel_cmd), 32'hFFFF_FFFC);
    pin(7, 1'b0, 80);
    wr(8'h08, 32'h5);
    start_try(32'h0000_0C02, 6'h00, 1, 6'd5);
    start_try(32'h0000_0C00, 6'h00, 0, 6'd5);
    main_running <= 1'b1;
    start_try(32'h0000_0C02, 6'h00, 0, 6'd5);
    main_running <= 1'b0;
    expansion_present <= 1'b1;
    start_try(32'h0000_0C06, 6'b101101, 1, 6'd45);
    expansion_present <= 1'b0;
    start_try(32'h0000_0C06, 6'b110001, 0, 6'd45);
    start_try(32'h0000_0C06, 6'b011111, 1, 6'd31);
    start_try(32'h0000_0406, 6'b101111, 1, 6'd2);
    sw_want[15:10] <= 6'h0;
    wr(8'h00, 32'h0000_0C01);
    chk("limits closed", {31'h0, limits_ok}, 32'h1);
    any_running <= 1'b1;
    pin(0, 1'b1, 40);
    chk("abort count", 32'(n_abort), 32'h1);
    chk("limits open", {31'h0, limits_ok}, 32'h0);
    motion_at_rest <= 1'b1;
    cyc(10);
    chk("error program", {25'h0, last_sys, last_num}, {25'h0, 1'b1, 6'd27});
    any_running <= 1'b0;
    pin(0, 1'b0, 40);
    chk("limit release", 32'(n_abort), 32'h1);
    wr(8'h00, 32'h0000_0C08);
    pin(10, 1'b1, 4);
    enc_a_pos <= 32'h0000_0111;
    pin(10, 1'b0, 4);
    rd(8'h20, rv);
    chk("capture one a", rv, 32'h1234_5678);
    rd(8'h24, rv);
    chk("capture one b", rv, 32'h0000_ABCD);
    rd(8'h18, rv);
    chk("occurred one", {31'h0, rv[16]}, 32'h1);
    wr(8'h1C, 32'h2);
    rd(8'h18, rv);
    chk("occurred one clear", {31'h0, rv[16]}, 32'h0);
    pin(11, 1'b1, 4);
    pin(11, 1'b0, 4);
    rd(8'h28, rv);
    chk("capture two off", rv, 32'h0);
    wr(8'h00, 32'h0000_0C10);
    wr(8'h1C, 32'h1);
    cyc(2);
    rd(8'h28, rv);
    chk("forced capture two", rv, 32'h0000_0111);
    wr(8'h00, 32'h0000_0C68);
    pin(10, 1'b1, 4);
    pin(10, 1'b0, 4);
    rd(8'h30, rv);
    chk("latched position", rv, 32'h0000_ABCD);
    wr(8'h04, 32'h0000_74C5);
    wr(8'h00, 32'h0000_0D00);
    pin(6, 1'b1, 40);
    pin(4, 1'b1, 200);
    chk("stop on", {31'h0, stop_flag}, 32'h1);
    chk("jog under stop", 32'(jog_vel_cmd), 32'h4);
    pin(4, 1'b0, 40);
    chk("stop off", {31'h0, stop_flag}, 32'h0);
    pin(6, 1'b0, 80);
    any_running <= 1'b1;
    pin(5, 1'b1, 40);
    chk("home while busy", 32'(n_home), 32'h0);
    any_running <= 1'b0;
    pin(5, 1'b0, 40);
    pin(5, 1'b1, 40);
    pin(5, 1'b0, 40);
    chk("home once", 32'(n_home), 32'h1);
    diag_done <= 1'b1;
    pin(12, 1'b1, 60);
    chk("auto program", {25'h0, last_sys, last_num}, {25'h0, 1'b1, 6'd0});
    pin(12, 1'b0, 60);
    chk("reset cycle idle", {29'h0, hreset_phase}, 32'h0);
    finish_test();
  end
endmodule // tb_top
